/* File: hdl/rtc_calendar_clock.sv */
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Calendar clock with scan-synchronous set and read words
// ****************************************************************

module rtc_calendar_clock
    import rtc_pkg::*;
(
    // Clock, enable and resets
    input wire logic CLK,
    input wire logic CE,
    input wire logic SYS_RST,
    input wire logic BAT_RST,
    // Battery timebase
    input wire logic SEC_TICK,
    // Program scan engine
    input wire logic SCAN_END,
    input wire logic SET_INSTR,
    input wire logic BAT_FAULT,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Interrupt
    output logic IRQ
);

    // ****************************************************************
    // State
    // ****************************************************************

    typedef struct packed {
        bus_phase_t phase;
        logic [31:0] rdata;
        word_set_t rd;
        word_set_t set;
        logic strobe;
        logic instr_pend;
        logic clk_err;
        logic [EVT_W-1:0] evt;
        logic [EVT_W-1:0] mask;
    } main_state_t;

    main_state_t r;
    main_state_t n;

    logic req;
    logic wr_go;
    logic pend;
    logic set_ok;
    logic commit_ok;
    logic commit_bad;
    logic strobe_wr;
    logic tb_load;
    cal_time_t set_time;
    cal_time_t tb_now;

    // Address group decode, used by both the read and the write paths.
    function automatic logic in_grp(input logic [ADDR_W-1:0] a, input logic [1:0] g);
        return a[5:4] == g;
    endfunction : in_grp

    // Merges a write into a 16-bit word under the two low byte lanes.
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] be);
        logic [15:0] v;
        v = old;
        if (be[0])
            v[7:0] = d[7:0];
        if (be[1])
            v[15:8] = d[15:8];
        return v;
    endfunction : merge16

    // ****************************************************************
    // Submodules
    // ****************************************************************

    assign set_time = from_words(r.set);

    rtc_set_check u_check (
        .req_time(set_time),
        .ok(set_ok)
    );

    rtc_timebase u_timebase (
        .clk(CLK),
        .bat_rst(BAT_RST),
        .ce(CE),
        .tick(SEC_TICK),
        .load(tb_load),
        .load_time(set_time),
        .now(tb_now)
    );

    // ****************************************************************
    // Commit decision
    // ****************************************************************

    // A request is any latched instruction or strobe, or an instruction arriving now.
    always_comb
    begin
        req = AVS_READ || AVS_WRITE;
        wr_go = AVS_WRITE && (r.phase == BUS_ACK);
        pend = r.instr_pend || SET_INSTR || r.strobe;
        commit_ok = SCAN_END && pend && set_ok;
        commit_bad = SCAN_END && pend && !set_ok;
        strobe_wr = wr_go && (AVS_ADDRESS == OFS_CTRL) && AVS_BYTEENABLE[0]
            && AVS_WRITEDATA[CTRL_STROBE_BIT];
        tb_load = commit_ok;
    end

    // ****************************************************************
    // Next state
    // ****************************************************************

    // Clears are applied first and sets last, so an event coinciding with its clear wins.
    always_comb
    begin
        n = r;

        // Bus phase: one wait state, read data captured on entry to the ack phase.
        unique case (r.phase)
            BUS_IDLE:
            begin
                if (req)
                    n.phase = BUS_ACK;
                n.rdata = 32'h0000_0000;
                if (AVS_READ)
                begin
                    if (in_grp(AVS_ADDRESS, GRP_RD))
                        n.rdata = {16'h0000, r.rd[AVS_ADDRESS[3:2]]};
                    else if (in_grp(AVS_ADDRESS, GRP_SET))
                        n.rdata = {16'h0000, r.set[AVS_ADDRESS[3:2]]};
                    else if (AVS_ADDRESS == OFS_CTRL)
                        n.rdata[CTRL_STROBE_BIT] = r.strobe;
                    else if (AVS_ADDRESS == OFS_EVT)
                        n.rdata[EVT_W-1:0] = r.evt;
                    else if (AVS_ADDRESS == OFS_MASK)
                        n.rdata[EVT_W-1:0] = r.mask;
                    else if (AVS_ADDRESS == OFS_STATE)
                    begin
                        n.rdata[STATE_ERR_BIT] = r.clk_err;
                        n.rdata[STATE_PEND_BIT] = pend;
                    end
                end
            end
            BUS_ACK:
            begin
                n.phase = BUS_IDLE;
            end
            default:
            begin
                n.phase = BUS_IDLE;
            end
        endcase

        // Scan end: copy the time out and settle any pending set request.
        if (SCAN_END)
        begin
            n.rd = to_words(tb_now);
            n.instr_pend = 1'b0;
            n.strobe = 1'b0;
            if (commit_ok)
                n.clk_err = 1'b0;
        end

        // Instructions seen mid-scan wait for the scan end.
        if (SET_INSTR && !SCAN_END)
            n.instr_pend = 1'b1;

        // Register writes; the read words have no write path.
        if (wr_go)
        begin
            if (in_grp(AVS_ADDRESS, GRP_SET))
                n.set[AVS_ADDRESS[3:2]] = merge16(r.set[AVS_ADDRESS[3:2]], AVS_WRITEDATA,
                                                  AVS_BYTEENABLE);
            if ((AVS_ADDRESS == OFS_EVT) && AVS_BYTEENABLE[0])
                n.evt = r.evt & ~AVS_WRITEDATA[EVT_W-1:0];
            if ((AVS_ADDRESS == OFS_MASK) && AVS_BYTEENABLE[0])
                n.mask = AVS_WRITEDATA[EVT_W-1:0];
        end

        // A strobe written during the scan end is kept for the next scan.
        if (strobe_wr)
            n.strobe = 1'b1;

        // Sticky events and the error flag; sets override clears above.
        if (commit_ok)
            n.evt[EVT_COMMIT] = 1'b1;
        if (commit_bad)
            n.evt[EVT_REJECT] = 1'b1;
        if (BAT_FAULT)
        begin
            n.clk_err = 1'b1;
            n.evt[EVT_FAULT] = 1'b1;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************

    // The read words are cleared on system reset and refilled at the first scan end.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            r.phase <= BUS_IDLE;
            r.rdata <= 32'h0000_0000;
            r.rd <= WORDS_RST;
            r.set <= WORDS_RST;
            r.strobe <= 1'b0;
            r.instr_pend <= 1'b0;
            r.clk_err <= 1'b0;
            r.evt <= EVT_RST;
            r.mask <= MASK_RST;
        end
        else if (CE)
        begin
            r <= n;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Waitrequest drops only in the ack phase with the clock enabled, so no access completes frozen.
    assign AVS_WAITREQUEST = req && !((r.phase == BUS_ACK) && CE);
    assign AVS_READDATA = r.rdata;
    assign IRQ = |(r.evt & r.mask);

    // ****************************************************************
    // Checks
    // ****************************************************************

    AST_COPY_AT_SCAN: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CE && SCAN_END) |=> (r.rd == to_words($past(tb_now))))
        else $error("Read words were not refreshed at scan end.");

    AST_WORD_ORDER: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CE && SCAN_END) |=> (r.rd[0][15:8] == $past(tb_now.month)
            && r.rd[3][7:0] == $past(tb_now.weekday)))
        else $error("Read word byte order is wrong.");

    AST_COMMIT_LOADS: assert property (@(posedge CLK) disable iff (SYS_RST || BAT_RST)
        (CE && SCAN_END && pend && set_ok) |=> (tb_now == $past(set_time)))
        else $error("A valid set request was not loaded.");

    AST_STROBE_COMMITS: assert property (@(posedge CLK) disable iff (SYS_RST || BAT_RST)
        (CE && r.strobe && SCAN_END && set_ok) |=> (tb_now == $past(set_time) && r.evt[EVT_COMMIT]))
        else $error("Strobe did not commit the set words.");

    AST_REJECT_KEEPS: assert property (@(posedge CLK) disable iff (SYS_RST || BAT_RST)
        (CE && SCAN_END && pend && !set_ok && !SEC_TICK) |=> (tb_now == $past(tb_now)
            && r.evt[EVT_REJECT]))
        else $error("A bad set request changed the time.");

    AST_WEEKDAY_AS_WRITTEN: assert property (@(posedge CLK) disable iff (SYS_RST || BAT_RST)
        (CE && commit_ok) |=> (tb_now.weekday == $past(r.set[3][7:0])))
        else $error("Weekday was not stored as written.");

    AST_ERR_CLEARED: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CE && commit_ok && !BAT_FAULT) |=> !r.clk_err)
        else $error("Clock error not cleared by a good write.");

    AST_STROBE_SELF_CLEAR: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CE && SCAN_END && !strobe_wr) |=> (!r.strobe ##1 (r.strobe || !$past(r.strobe))))
        else $error("Write strobe did not clear itself.");

    AST_ONE_WAIT: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CE && req && r.phase == BUS_IDLE) ##1 (CE && req) |-> !AVS_WAITREQUEST)
        else $error("Bus access did not complete after one wait state.");

    AST_RANGE_GATE: assert property (@(posedge CLK) disable iff (SYS_RST)
        (set_ok |-> (set_time.day != BCD_ZERO && set_time.hour <= HOUR_MAX
            && set_time.minute <= MINSEC_MAX)))
        else $error("Out-of-range time accepted.");

endmodule : rtc_calendar_clock

`default_nettype wire

/* File: hdl/rtc_pkg.sv */
//
// Functional notes
// - Time keeps counting on its battery timebase while system power is off.
// - Every scan end the current time is copied into the read words.
// - Read words: month/year, hour/day, second/minute, century/weekday; first item high.
// - Hours run 00 to 23 in 24-hour form, no AM/PM flag.
// - The set instruction loads the four set words into the clock at scan end.
// - Years 1984 to 2163 and months 01 to 12 are accepted.
// - Days 01 to 31 and hours 00 to 23 are accepted.
// - Minutes and seconds 00 to 59 are accepted.
// - Weekday is 0 to 6, Sunday is 0, Saturday is 6.
// - Setting the write strobe bit also commits the set words.
// - Any field out of format or range rejects the whole write.
// - The weekday is stored as written, even if it disagrees with the date.
// - A successful write clears the clock error condition.

package rtc_pkg;

    // ****************************************************************
    // Types
    // ****************************************************************

    typedef logic [7:0] bcd_t;

    typedef struct packed {
        bcd_t century;
        bcd_t year;
        bcd_t month;
        bcd_t day;
        bcd_t hour;
        bcd_t minute;
        bcd_t second;
        bcd_t weekday;
    } cal_time_t;

    typedef logic [3:0][15:0] word_set_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_phase_t;

    // ****************************************************************
    // Register map, byte addresses
    // ****************************************************************

    localparam int ADDR_W = 6;
    localparam logic [1:0] GRP_RD = 2'h0;
    localparam logic [1:0] GRP_SET = 2'h1;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h20;
    localparam logic [ADDR_W-1:0] OFS_EVT = 6'h24;
    localparam logic [ADDR_W-1:0] OFS_MASK = 6'h28;
    localparam logic [ADDR_W-1:0] OFS_STATE = 6'h2C;
    localparam int CTRL_STROBE_BIT = 0;
    localparam int STATE_ERR_BIT = 0;
    localparam int STATE_PEND_BIT = 1;
    localparam int EVT_W = 3;
    localparam int EVT_COMMIT = 0;
    localparam int EVT_REJECT = 1;
    localparam int EVT_FAULT = 2;
    localparam logic [EVT_W-1:0] MASK_RST = 3'h0;
    localparam logic [EVT_W-1:0] EVT_RST = 3'h0;
    localparam word_set_t WORDS_RST = 64'h0000_0000_0000_0000;

    // ****************************************************************
    // Ranges, all in BCD
    // ****************************************************************

    localparam bcd_t BCD_ZERO = 8'h00;
    localparam bcd_t BCD_ONE = 8'h01;
    localparam bcd_t CENT_MIN = 8'h19;
    localparam bcd_t CENT_MAX = 8'h21;
    localparam bcd_t YEAR_FIRST = 8'h84;
    localparam bcd_t YEAR_LAST = 8'h63;
    localparam bcd_t YEAR_MAX = 8'h99;
    localparam bcd_t MONTH_MAX = 8'h12;
    localparam bcd_t DAY_MAX = 8'h31;
    localparam bcd_t HOUR_MAX = 8'h23;
    localparam bcd_t MINSEC_MAX = 8'h59;
    localparam bcd_t WDAY_MAX = 8'h06;

    // Sunday 1984-01-01 00:00:00, taken only on a battery reset.
    localparam cal_time_t TIME_RST = 64'h1984_0101_0000_0000;

    // ****************************************************************
    // Functions
    // ****************************************************************

    // Both digits must be decimal.
    function automatic logic bcd_ok(input bcd_t b);
        return (b[7:4] <= 4'h9) && (b[3:0] <= 4'h9);
    endfunction : bcd_ok

    // Adds one to a valid two-digit BCD value, 99 wraps to 00.
    function automatic bcd_t bcd_inc(input bcd_t b);
        bcd_t v;
        v = b;
        if (b[3:0] == 4'h9)
        begin
            v[3:0] = 4'h0;
            v[7:4] = (b[7:4] == 4'h9) ? 4'h0 : b[7:4] + 4'h1;
        end
        else
        begin
            v[3:0] = b[3:0] + 4'h1;
        end
        return v;
    endfunction : bcd_inc

    // A BCD number is a multiple of four by its units digit and tens parity.
    function automatic logic bcd_div4(input bcd_t b);
        if (b[4])
            return (b[3:0] == 4'h2) || (b[3:0] == 4'h6);
        return (b[3:0] == 4'h0) || (b[3:0] == 4'h4) || (b[3:0] == 4'h8);
    endfunction : bcd_div4

    // Length of a month in BCD, with the full Gregorian leap rule.
    function automatic bcd_t month_days(input bcd_t mm, input bcd_t cc, input bcd_t yy);
        logic leap;
        leap = bcd_div4(yy) && ((yy != BCD_ZERO) || bcd_div4(cc));
        unique case (mm)
            8'h02: return leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default: return DAY_MAX;
        endcase
    endfunction : month_days

    // Packs a time into the four words, first-named item in the high byte.
    function automatic word_set_t to_words(input cal_time_t t);
        word_set_t w;
        w[0] = {t.month, t.year};
        w[1] = {t.hour, t.day};
        w[2] = {t.second, t.minute};
        w[3] = {t.century, t.weekday};
        return w;
    endfunction : to_words

    // Inverse of to_words.
    function automatic cal_time_t from_words(input word_set_t w);
        cal_time_t t;
        {t.month, t.year} = w[0];
        {t.hour, t.day} = w[1];
        {t.second, t.minute} = w[2];
        {t.century, t.weekday} = w[3];
        return t;
    endfunction : from_words

endpackage : rtc_pkg

/* File: hdl/rtc_set_check.sv */
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Range check of a requested time
// ****************************************************************

module rtc_set_check
    import rtc_pkg::*;
(
    // Requested time
    input wire cal_time_t req_time,
    // Verdict
    output logic ok
);

    logic digits_ok;
    logic year_ok;

    // Every byte must hold two decimal digits before any compare means anything.
    always_comb
    begin
        digits_ok = bcd_ok(req_time.century) && bcd_ok(req_time.year)
            && bcd_ok(req_time.month) && bcd_ok(req_time.day)
            && bcd_ok(req_time.hour) && bcd_ok(req_time.minute)
            && bcd_ok(req_time.second) && bcd_ok(req_time.weekday);
        // Valid BCD compares like binary, so raw byte compares are safe here.
        year_ok = (req_time.century >= CENT_MIN) && (req_time.century <= CENT_MAX)
            && !((req_time.century == CENT_MIN) && (req_time.year < YEAR_FIRST))
            && !((req_time.century == CENT_MAX) && (req_time.year > YEAR_LAST));
        ok = digits_ok && year_ok
            && (req_time.month >= BCD_ONE) && (req_time.month <= MONTH_MAX)
            && (req_time.day >= BCD_ONE) && (req_time.day <= DAY_MAX)
            && (req_time.hour <= HOUR_MAX)
            && (req_time.minute <= MINSEC_MAX) && (req_time.second <= MINSEC_MAX)
            && (req_time.weekday <= WDAY_MAX);
    end

endmodule : rtc_set_check

`default_nettype wire

/* File: hdl/rtc_timebase.sv */
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Battery-kept calendar counter
// ****************************************************************

module rtc_timebase
    import rtc_pkg::*;
(
    // Battery domain clock, enable and reset
    input wire logic clk,
    input wire logic bat_rst,
    input wire logic ce,
    // One-second tick and load request
    input wire logic tick,
    input wire logic load,
    input wire cal_time_t load_time,
    // Current time
    output cal_time_t now
);

    typedef struct packed {
        cal_time_t t;
    } tb_state_t;

    tb_state_t r;
    tb_state_t n;

    // Cascade of BCD counters; a load overrides the tick of the same cycle.
    always_comb
    begin
        n = r;
        if (load)
        begin
            n.t = load_time;
        end
        else if (tick)
        begin
            n.t.second = bcd_inc(r.t.second);
            if (r.t.second == MINSEC_MAX)
            begin
                n.t.second = BCD_ZERO;
                n.t.minute = bcd_inc(r.t.minute);
                if (r.t.minute == MINSEC_MAX)
                begin
                    n.t.minute = BCD_ZERO;
                    n.t.hour = (r.t.hour >= HOUR_MAX) ? BCD_ZERO : bcd_inc(r.t.hour);
                    if (r.t.hour >= HOUR_MAX)
                    begin
                        n.t.weekday = (r.t.weekday >= WDAY_MAX) ? BCD_ZERO : bcd_inc(r.t.weekday);
                        n.t.day = bcd_inc(r.t.day);
                        if (r.t.day >= month_days(r.t.month, r.t.century, r.t.year))
                        begin
                            n.t.day = BCD_ONE;
                            n.t.month = bcd_inc(r.t.month);
                            if (r.t.month >= MONTH_MAX)
                            begin
                                n.t.month = BCD_ONE;
                                n.t.year = bcd_inc(r.t.year);
                                if (r.t.year == YEAR_MAX)
                                    n.t.century = bcd_inc(r.t.century);
                            end
                        end
                    end
                end
            end
        end
    end

    // Only the battery reset clears the time; system reset never reaches here.
    always_ff @(posedge clk)
    begin
        if (bat_rst)
            r <= TIME_RST;
        else if (ce)
            r <= n;
    end

    assign now = r.t;

    AST_TIME_HOLDS: assert property (@(posedge clk) disable iff (bat_rst)
        (!tick && !load) |=> (now == $past(now)))
        else $error("Time changed without a tick or a load.");

    AST_HOUR_WRAP: assert property (@(posedge clk) disable iff (bat_rst)
        (ce && tick && !load && now.hour == HOUR_MAX && now.minute == MINSEC_MAX
            && now.second == MINSEC_MAX) |=> (now.hour == BCD_ZERO))
        else $error("Hour did not wrap from 23 to 00.");

endmodule : rtc_timebase

`default_nettype wire

/* File: tb/scan_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Program scan engine stand-in
// ****************************************************************

module scan_model (
    // Clock and requests from the bench
    input wire logic clk,
    input wire logic scan_go,
    input wire logic instr_go,
    input wire logic tick_go,
    // Pulses towards the clock block
    output logic scan_end,
    output logic set_instr,
    output logic sec_tick
);
    // Each request becomes a one-cycle pulse; an instruction may come mid-scan or at scan end.
    always_ff @(posedge clk)
    begin
        scan_end <= scan_go;
        set_instr <= instr_go;
        sec_tick <= tick_go;
    end
endmodule : scan_model

`default_nettype wire

/* File: tb/rtc_calendar_clock_test.sv */
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Self-checking bench for the calendar clock
// ****************************************************************

module rtc_calendar_clock_test
    import rtc_pkg::*;
;
    logic CLK, CE, SYS_RST, BAT_RST, BAT_FAULT, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IRQ;
    logic scan_go, instr_go, tick_go, SEC_TICK, SCAN_END, SET_INSTR;
    logic [ADDR_W-1:0] AVS_ADDRESS;
    logic [3:0] AVS_BYTEENABLE;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, d, rs;
    int miscompares, checks, k;
    int t[8], mdl[8];
    int fld[11] = '{2, 2, 3, 3, 4, 5, 6, 7, 1, 0, 0};
    int val[11] = '{13, 0, 32, 0, 24, 60, 60, 7, 64, 22, 18};

    rtc_calendar_clock rtc_calendar_clock_i (.CLK(CLK), .CE(CE), .SYS_RST(SYS_RST),
        .BAT_RST(BAT_RST), .SEC_TICK(SEC_TICK), .SCAN_END(SCAN_END), .SET_INSTR(SET_INSTR),
        .BAT_FAULT(BAT_FAULT), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ));
    scan_model scan_model_i (.clk(CLK), .scan_go(scan_go), .instr_go(instr_go),
        .tick_go(tick_go), .scan_end(SCAN_END), .set_instr(SET_INSTR), .sec_tick(SEC_TICK));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Model words: two decimal digits per byte, first-named item high.
    function automatic logic [7:0] b(input int x);
        return 8'((x / 10) * 16 + x % 10);
    endfunction : b

    function automatic logic [31:0] word(input int v[8], input int i);
        logic [15:0] r[4];
        r = '{{b(v[2]), b(v[1])}, {b(v[4]), b(v[3])}, {b(v[6]), b(v[5])}, {b(v[0]), b(v[7])}};
        return {16'h0000, r[i]};
    endfunction : word

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One bus access; the request stands until waitrequest is seen low, a hang ends the run.
    task automatic bus(input logic [ADDR_W-1:0] a, input logic [31:0] wd, input bit wr);
        int n;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= wd;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        for (n = 0; n < 20; n++)
        begin
            @(posedge CLK);
            if (AVS_WAITREQUEST === 1'b0)
                break;
        end
        d = AVS_READDATA;
        if (n == 20)
        begin
            miscompares++;
            report_and_stop();
        end
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        @(posedge CLK);
    endtask : bus

    task automatic pulse(input bit s, input bit i, input bit tk);
        scan_go <= s;
        instr_go <= i;
        tick_go <= tk;
        @(posedge CLK);
        scan_go <= 1'b0;
        instr_go <= 1'b0;
        tick_go <= 1'b0;
        repeat (2) @(posedge CLK);
    endtask : pulse

    task automatic reads();
        for (int i = 0; i < 4; i++)
        begin
            bus(ADDR_W'(4 * i), 32'h0000_0000, 1'b0);
            chk(d, word(mdl, i));
        end
    endtask : reads

    // Loads t, commits it by instruction or strobe, then checks verdict and new time.
    task automatic set_time(input bit instr);
        bit ok;
        ok = t[0] >= 19 && t[0] <= 21 && !(t[0] == 19 && t[1] < 84) && !(t[0] == 21 && t[1] > 63)
            && t[2] >= 1 && t[2] <= 12 && t[3] >= 1 && t[3] <= 31 && t[4] <= 23 && t[5] <= 59
            && t[6] <= 59 && t[7] <= 6;
        for (int i = 0; i < 4; i++)
            bus(ADDR_W'(16 + 4 * i), word(t, i), 1'b1);
        if (!instr)
            bus(OFS_CTRL, 32'h0000_0001, 1'b1);
        pulse(1'b0, instr && k[1], 1'b0);
        pulse(1'b1, instr && !k[1], 1'b0);
        bus(OFS_EVT, 32'h0000_0000, 1'b0);
        chk(d, ok ? 32'h0000_0001 : 32'h0000_0002);
        chk({31'h0, IRQ}, {31'h0, ok});
        bus(OFS_CTRL, 32'h0000_0000, 1'b0);
        chk(d, 32'h0000_0000);
        bus(OFS_EVT, 32'h0000_0003, 1'b1);
        if (ok)
            mdl = t;
        pulse(1'b1, 1'b0, 1'b0);
        reads();
    endtask : set_time

    // Free-running system clock.
    initial
    begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    // Main sequence; the verdict is given at its end, or earlier by bus when an access hangs.
    initial
    begin
        {CE, SYS_RST, BAT_RST} = 3'b111;
        {BAT_FAULT, AVS_READ, AVS_WRITE, scan_go, instr_go, tick_go} = '0;
        AVS_ADDRESS = '0;
        AVS_BYTEENABLE = 4'hf;
        AVS_WRITEDATA = '0;
        {miscompares, checks} = '0;
        rs = 32'hae2c_aebc;
        mdl = '{19, 84, 1, 1, 0, 0, 0, 0};
        repeat (8) @(posedge CLK);
        SYS_RST <= 1'b0;
        BAT_RST <= 1'b0;
        @(posedge CLK);
        bus(ADDR_W'(0), 32'h0000_0000, 1'b0);
        chk(d, 32'h0000_0000);
        pulse(1'b1, 1'b0, 1'b0);
        reads();
        bus(OFS_MASK, 32'h0000_0001, 1'b1);
        t = '{20, 24, 2, 29, 23, 59, 58, 3};
        set_time(1'b0);
        pulse(1'b0, 1'b0, 1'b1);
        pulse(1'b0, 1'b0, 1'b1);
        mdl = '{20, 24, 3, 1, 0, 0, 0, 4};
        pulse(1'b1, 1'b0, 1'b0);
        reads();
        CE <= 1'b0;
        pulse(1'b1, 1'b0, 1'b1);
        CE <= 1'b1;
        pulse(1'b1, 1'b0, 1'b0);
        reads();
        for (k = 0; k < 3; k++)
        begin
            rs = lfsr(rs);
            t = '{21, 63, 12, 31, 23, rs[7:0] % 60, rs[15:8] % 59, rs[18:16] % 7};
            set_time(k[0]);
        end
        pulse(1'b0, 1'b0, 1'b1);
        mdl[6]++;
        bus(ADDR_W'(0), 32'h0000_ffff, 1'b1);
        bus(ADDR_W'(0), 32'h0000_0000, 1'b0);
        chk(d, word(mdl, 0));
        SYS_RST <= 1'b1;
        @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        pulse(1'b1, 1'b0, 1'b0);
        reads();
        bus(OFS_MASK, 32'h0000_0001, 1'b1);
        for (k = 0; k < 11; k++)
        begin
            t = mdl;
            t[fld[k]] = val[k];
            set_time(k[0]);
        end
        t = mdl;
        t[0] = 19;
        t[1] = 83;
        set_time(1'b0);
        t[1] = 84;
        set_time(1'b1);
        BAT_FAULT <= 1'b1;
        @(posedge CLK);
        BAT_FAULT <= 1'b0;
        @(posedge CLK);
        bus(OFS_STATE, 32'h0000_0000, 1'b0);
        chk(d, 32'h0000_0001);
        bus(OFS_EVT, 32'h0000_0007, 1'b1);
        set_time(1'b0);
        bus(OFS_STATE, 32'h0000_0000, 1'b0);
        chk(d, 32'h0000_0000);
        AVS_BYTEENABLE <= 4'h1;
        bus(ADDR_W'(16), 32'h0000_ffff, 1'b1);
        AVS_BYTEENABLE <= 4'hf;
        bus(ADDR_W'(16), 32'h0000_0000, 1'b0);
        chk(d, {16'h0000, b(mdl[2]), 8'hff});
        bus(ADDR_W'(48), 32'h0000_0000, 1'b0);
        chk(d, 32'h0000_0000);
        report_and_stop();
    end
endmodule : rtc_calendar_clock_test

`default_nettype wire
